// ---- pkg/swlap_regs.svh ----
// Constants for the stopwatch lap timer: prescaler and unit divisions.
// Assumes a 40 MHz system clock; included by the core and the testbench.
`ifndef SWLAP_REGS_SVH
`define SWLAP_REGS_SVH

`define SWLAP_CLK_HZ 40000000
`define SWLAP_TICK_MS 10
`define SWLAP_TICK_CYCLES ((`SWLAP_CLK_HZ / 1000) * `SWLAP_TICK_MS)
`define SWLAP_TICKS_PER_SEC 100
`define SWLAP_SECS_PER_MIN 60
`define SWLAP_MINS_PER_HOUR 60
`define SWLAP_COUNT_W 32
`define SWLAP_RESET_VALUE 32'h0000_0000

`endif

// ---- pkg/swlap_pkg.sv ----
// Types for the stopwatch lap timer.
// Assumes nothing beyond the constants header.
package swlap_pkg;
	typedef enum logic [1:0] {
		SWLAP_BASE_10MS,
		SWLAP_BASE_SEC,
		SWLAP_BASE_MIN,
		SWLAP_BASE_HOUR
	} swlap_base_type;
endpackage : swlap_pkg

// ---- core/swlap_timer.sv ----
// Stopwatch with lap capture, counting in a selectable time base.
// Assumes enable, lap and clear come from logic on ref_clk (no synchronisers).
`timescale 1ns/1ps
`default_nettype none
`include "swlap_regs.svh"

module swlap_timer
	import swlap_pkg::*;
#(
	parameter int TICK_CYCLES = `SWLAP_TICK_CYCLES // Clock cycles per 10 ms tick
)
(
	input wire logic ref_clk, // 40 MHz system clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic enable, // Run input
	input wire logic lap, // Lap capture input
	input wire logic clear, // Clears elapsed and lap time, active high
	input wire swlap_base_type time_base, // Unit of counting
	output logic [`SWLAP_COUNT_W-1:0] time_value_out // Elapsed or lap time
);

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	logic enable_q;
	logic lap_q;
	logic enable_rise;
	logic enable_fall;
	logic lap_rise;
	logic lap_fall;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			enable_q <= 1'b0;
			lap_q <= 1'b0;
		end else begin
			enable_q <= enable;
			lap_q <= lap;
		end
	end

	assign enable_rise = enable & ~enable_q;
	assign enable_fall = ~enable & enable_q;
	assign lap_rise = lap & ~lap_q;
	assign lap_fall = ~lap & lap_q;

	// ----------------------------------------
	// Prescaler and unit dividers
	// ----------------------------------------
	// The dividers restart with each run so the first unit is a full unit.
	// The prescaler is 19 bits wide, so TICK_CYCLES must stay below 524289.
	logic [18:0] presc;
	logic [6:0] hund;
	logic [5:0] secs;
	logic [5:0] mins;
	logic [18:0] next_presc;
	logic [6:0] next_hund;
	logic [5:0] next_secs;
	logic [5:0] next_mins;
	logic tick_10ms;
	logic tick_sec;
	logic tick_min;
	logic tick_hour;
	logic unit_tick;

	always_comb begin
		next_presc = presc;
		next_hund = hund;
		next_secs = secs;
		next_mins = mins;
		tick_10ms = 1'b0;
		tick_sec = 1'b0;
		tick_min = 1'b0;
		tick_hour = 1'b0;
		if (clear || enable_rise || !enable) begin
			next_presc = '0;
			next_hund = '0;
			next_secs = '0;
			next_mins = '0;
		end else if (presc == 19'(TICK_CYCLES - 1)) begin
			next_presc = '0;
			tick_10ms = 1'b1;
			if (hund == 7'(`SWLAP_TICKS_PER_SEC - 1)) begin
				next_hund = '0;
				tick_sec = 1'b1;
				if (secs == 6'(`SWLAP_SECS_PER_MIN - 1)) begin
					next_secs = '0;
					tick_min = 1'b1;
					if (mins == 6'(`SWLAP_MINS_PER_HOUR - 1)) begin
						next_mins = '0;
						tick_hour = 1'b1;
					end else begin
						next_mins = mins + 6'h01;
					end
				end else begin
					next_secs = secs + 6'h01;
				end
			end else begin
				next_hund = hund + 7'h01;
			end
		end else begin
			next_presc = presc + 19'h00001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			presc <= '0;
			hund <= '0;
			secs <= '0;
			mins <= '0;
		end else begin
			presc <= next_presc;
			hund <= next_hund;
			secs <= next_secs;
			mins <= next_mins;
		end
	end

	always_comb begin
		case (time_base)
			SWLAP_BASE_10MS: unit_tick = tick_10ms;
			SWLAP_BASE_SEC: unit_tick = tick_sec;
			SWLAP_BASE_MIN: unit_tick = tick_min;
			default: unit_tick = tick_hour;
		endcase
	end

	// ----------------------------------------
	// Elapsed count, lap store and output
	// ----------------------------------------
	logic [`SWLAP_COUNT_W-1:0] elapsed;
	logic [`SWLAP_COUNT_W-1:0] lap_time;
	logic show_lap;
	logic [`SWLAP_COUNT_W-1:0] next_elapsed;
	logic [`SWLAP_COUNT_W-1:0] next_lap_time;
	logic next_show_lap;
	logic [`SWLAP_COUNT_W-1:0] next_out;

	always_comb begin
		next_elapsed = elapsed;
		next_lap_time = lap_time;
		next_show_lap = show_lap;
		if (clear) begin
			next_elapsed = `SWLAP_RESET_VALUE;
			next_lap_time = `SWLAP_RESET_VALUE;
			next_show_lap = lap;
		end else begin
			if (enable_rise) begin
				next_elapsed = `SWLAP_RESET_VALUE;
			end else if (enable && unit_tick) begin
				next_elapsed = elapsed + 32'h0000_0001;
			end
			// A falling enable simply stops the increments above.
			if (lap_rise) begin
				next_lap_time = elapsed;
				next_show_lap = 1'b1;
			end else if (lap_fall) begin
				next_show_lap = 1'b0;
			end
		end
		if (enable_rise && !clear) begin
			next_out = `SWLAP_RESET_VALUE;
		end else if (next_show_lap) begin
			next_out = next_lap_time;
		end else begin
			next_out = next_elapsed;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			elapsed <= '0;
			lap_time <= '0;
			show_lap <= 1'b0;
			time_value_out <= '0;
		end else begin
			elapsed <= next_elapsed;
			lap_time <= next_lap_time;
			show_lap <= next_show_lap;
			time_value_out <= next_out;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// A separate cycle count since the last restart or tick, so the tick spacing is
	// judged against a count that the prescaler itself does not drive.
	logic [18:0] gap_cnt;
	logic [18:0] next_gap_cnt;

	always_comb begin
		next_gap_cnt = gap_cnt + 19'h00001;
		if (clear || enable_rise || !enable || tick_10ms) begin
			next_gap_cnt = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			gap_cnt <= '0;
		end else begin
			gap_cnt <= next_gap_cnt;
		end
	end

	property p_rise_clears;
		@(posedge ref_clk) disable iff (!reset_n)
		enable_rise |=> (elapsed == 32'h0) && (time_value_out == 32'h0);
	endproperty
	a_rise_clears: assert property (p_rise_clears) else $error("run start did not clear");

	property p_hold_when_off;
		@(posedge ref_clk) disable iff (!reset_n)
		(!enable && !enable_q && !clear) |=> $stable(elapsed);
	endproperty
	a_hold_when_off: assert property (p_hold_when_off) else $error("count moved while stopped");

	property p_lap_capture;
		@(posedge ref_clk) disable iff (!reset_n)
		(lap_rise && !clear && !enable_rise) |=>
			(lap_time == $past(elapsed)) && (time_value_out == lap_time);
	endproperty
	a_lap_capture: assert property (p_lap_capture) else $error("lap not captured");

	property p_lap_release;
		@(posedge ref_clk) disable iff (!reset_n)
		(lap_fall && !enable_rise) |=> time_value_out == elapsed;
	endproperty
	a_lap_release: assert property (p_lap_release) else $error("output not back to count");

	property p_clear;
		@(posedge ref_clk) disable iff (!reset_n)
		clear |=> (elapsed == 32'h0) && (lap_time == 32'h0);
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not zero values");

	property p_step;
		@(posedge ref_clk) disable iff (!reset_n)
		(enable && enable_q && !clear && unit_tick) |=> elapsed == $past(elapsed) + 32'h1;
	endproperty
	a_step: assert property (p_step) else $error("count missed a unit");

	property p_no_step;
		@(posedge ref_clk) disable iff (!reset_n)
		(!unit_tick && !enable_rise && !clear) |=> $stable(elapsed);
	endproperty
	a_no_step: assert property (p_no_step) else $error("count moved between units");

	property p_show_lap;
		@(posedge ref_clk) disable iff (!reset_n)
		(lap && lap_q && !clear && !enable_rise) |=> time_value_out == lap_time;
	endproperty
	a_show_lap: assert property (p_show_lap) else $error("lap not shown");

	property p_show_count;
		@(posedge ref_clk) disable iff (!reset_n)
		(!lap && !lap_q && !enable_rise) |=> time_value_out == elapsed;
	endproperty
	a_show_count: assert property (p_show_count) else $error("count not shown");

	property p_tick_period;
		@(posedge ref_clk) disable iff (!reset_n)
		tick_10ms |-> gap_cnt == 19'(TICK_CYCLES - 1);
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("tick too close");

	property p_tick_due;
		@(posedge ref_clk) disable iff (!reset_n)
		(gap_cnt == 19'(TICK_CYCLES - 1) && enable && !enable_rise && !clear) |-> tick_10ms;
	endproperty
	a_tick_due: assert property (p_tick_due) else $error("tick missing");

	property p_unit_chain;
		@(posedge ref_clk) disable iff (!reset_n)
		!((tick_sec && !tick_10ms) || (tick_min && !tick_sec) || (tick_hour && !tick_min));
	endproperty
	a_unit_chain: assert property (p_unit_chain) else $error("unit tick out of step");

	property p_fall_freeze;
		@(posedge ref_clk) disable iff (!reset_n)
		(enable_fall && !clear) |=> $stable(elapsed);
	endproperty
	a_fall_freeze: assert property (p_fall_freeze) else $error("count moved at stop");

	property p_lap_store;
		@(posedge ref_clk) disable iff (!reset_n)
		(!lap_rise && !clear) |=> $stable(lap_time);
	endproperty
	a_lap_store: assert property (p_lap_store) else $error("lap time moved");

	property p_clear_wins;
		@(posedge ref_clk) disable iff (!reset_n)
		(clear && (enable_rise || lap_rise)) |=>
			(elapsed == 32'h0) && (lap_time == 32'h0) && (time_value_out == 32'h0);
	endproperty
	a_clear_wins: assert property (p_clear_wins) else $error("edge beat clear");

endmodule : swlap_timer
`default_nettype wire

// ---- tb/swlap_ctrl_model.sv ----
// Model of the control program that drives the run, lap and clear levels.
// Assumes one clock shared with the timer; it changes levels 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module swlap_ctrl_model (
	input wire logic ref_clk, // System clock
	output logic enable, // Run level
	output logic lap, // Lap level
	output logic clear // Clear level
);
	initial begin
		enable = 1'b0;
		lap = 1'b0;
		clear = 1'b0;
	end

	// Levels only move just after an edge, so the timer never sees a half-cycle glitch.
	task automatic drive(input logic en, input logic lp, input logic cl);
		@(posedge ref_clk);
		#1;
		enable = en;
		lap = lp;
		clear = cl;
	endtask : drive
endmodule : swlap_ctrl_model

`default_nettype wire

// ---- tb/swlap_timer_tb.sv ----
// Self-checking bench for the stopwatch lap timer in all four time bases.
// Assumes the tick length can be shortened so whole seconds and minutes fit in a run.
`timescale 1ns/1ps
`default_nettype none
`include "swlap_regs.svh"

module swlap_timer_tb;
	import swlap_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	wire logic enable;
	wire logic lap;
	wire logic clear;
	swlap_base_type time_base = SWLAP_BASE_10MS;
	logic [31:0] time_value_out;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	// A short tick keeps whole units within the run; an hour is still out of reach.
	localparam int TICK = 4;
	localparam int SEC_CYC = TICK * `SWLAP_TICKS_PER_SEC;
	localparam int MIN_CYC = SEC_CYC * `SWLAP_SECS_PER_MIN;
	localparam int LIMIT = 3 * MIN_CYC;

	always #12.5 ref_clk = ~ref_clk;

	swlap_ctrl_model i_swlap_ctrl_model (.ref_clk(ref_clk), .enable(enable), .lap(lap),
		.clear(clear));
	swlap_timer #(.TICK_CYCLES(TICK)) i_swlap_timer (.ref_clk(ref_clk), .reset_n(reset_n),
		.enable(enable), .lap(lap), .clear(clear), .time_base(time_base),
		.time_value_out(time_value_out));

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	// The output is registered, so it is judged 1 ns after the edge that loads it.
	task automatic chk(input string what, input logic [31:0] exp);
		n_tests++;
		if (time_value_out !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %0h seen %0h", what, exp, time_value_out);
		end
	endtask : chk

	// Lets n edges pass and stops 1 ns after the last, where the inputs also move.
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_cyc

	task automatic wrap_up;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > LIMIT) begin
			error_cnt++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// The run starts at the edge that samples enable high; ticks follow every TICK edges.
	task automatic t_start_and_tick;
		i_swlap_ctrl_model.drive(1'b1, 1'b0, 1'b0);
		wait_cyc(1);
		chk("start", 32'h0);
		wait_cyc(TICK - 1);
		chk("before tick", 32'h0);
		wait_cyc(1);
		chk("first tick", 32'h1);
		wait_cyc(TICK - 1);
		chk("before second tick", 32'h1);
		wait_cyc(1);
		chk("second tick", 32'h2);
	endtask : t_start_and_tick

	task automatic t_lap_and_stop;
		i_swlap_ctrl_model.drive(1'b1, 1'b1, 1'b0);
		wait_cyc(1);
		chk("lap capture", 32'h2);
		wait_cyc(2);
		chk("lap while running", 32'h2);
		i_swlap_ctrl_model.drive(1'b0, 1'b1, 1'b0);
		wait_cyc(1);
		chk("stopped lap", 32'h2);
		i_swlap_ctrl_model.drive(1'b0, 1'b0, 1'b0);
		wait_cyc(1);
		chk("stopped count", 32'h3);
		wait_cyc(2 * TICK);
		chk("frozen count", 32'h3);
	endtask : t_lap_and_stop

	task automatic t_restart_with_lap;
		i_swlap_ctrl_model.drive(1'b0, 1'b1, 1'b0);
		wait_cyc(1);
		chk("lap while stopped", 32'h3);
		i_swlap_ctrl_model.drive(1'b1, 1'b1, 1'b0);
		wait_cyc(1);
		chk("restart zero", 32'h0);
		wait_cyc(1);
		chk("lap kept", 32'h3);
		i_swlap_ctrl_model.drive(1'b1, 1'b0, 1'b0);
		wait_cyc(1);
		chk("count restarted", 32'h0);
		wait_cyc(1);
		chk("count after restart", 32'h1);
	endtask : t_restart_with_lap

	// Clear meets a lap edge in the same cycle; the lap edge must be lost.
	task automatic t_clear;
		i_swlap_ctrl_model.drive(1'b1, 1'b1, 1'b1);
		i_swlap_ctrl_model.drive(1'b1, 1'b1, 1'b0);
		chk("cleared", 32'h0);
		wait_cyc(4);
		chk("cleared lap kept", 32'h0);
		i_swlap_ctrl_model.drive(1'b1, 1'b0, 1'b0);
		wait_cyc(1);
		chk("count after clear", 32'h1);
	endtask : t_clear

	// Each base is set while stopped, so the run starts with a full unit.
	task automatic t_bases;
		i_swlap_ctrl_model.drive(1'b0, 1'b0, 1'b0);
		time_base = SWLAP_BASE_SEC;
		i_swlap_ctrl_model.drive(1'b1, 1'b0, 1'b0);
		wait_cyc(SEC_CYC);
		chk("second not yet", 32'h0);
		wait_cyc(1);
		chk("one second", 32'h1);
		i_swlap_ctrl_model.drive(1'b0, 1'b0, 1'b0);
		time_base = SWLAP_BASE_MIN;
		i_swlap_ctrl_model.drive(1'b1, 1'b0, 1'b0);
		wait_cyc(MIN_CYC);
		chk("minute not yet", 32'h0);
		wait_cyc(1);
		chk("one minute", 32'h1);
		i_swlap_ctrl_model.drive(1'b0, 1'b0, 1'b0);
		time_base = SWLAP_BASE_HOUR;
		i_swlap_ctrl_model.drive(1'b1, 1'b0, 1'b0);
		wait_cyc(MIN_CYC + 1);
		chk("hour not yet", 32'h0);
	endtask : t_bases

	initial begin
		repeat (6) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		wait_cyc(1);
		chk("after reset", 32'h0);
		t_start_and_tick();
		t_lap_and_stop();
		t_restart_with_lap();
		t_clear();
		t_bases();
		wrap_up();
	end
endmodule : swlap_timer_tb

`default_nettype wire
